// ===== core/sbc_counter_b.sv
// counter b: autoreload, capture and baud generator
`timescale 1ns/1ps
module sbc_counter_b
  import sbc_pkg::*;
(
  input  wire logic       core_clk,     // core clock
  input  wire logic       resetn,       // sync reset, low
  input  wire logic [7:0] ctrl,         // counter b control byte
  input  wire logic       ovf_clr,      // clear overflow flag
  input  wire logic       ext_clr,      // clear external flag
  input  wire logic       count_evt,    // pin count event
  input  wire logic       trig_fall,    // trigger pin falling edge
  input  wire logic       wr_lo,        // write count low
  input  wire logic       wr_hi,        // write count high
  input  wire logic       wr_rlo,       // write reload low
  input  wire logic       wr_rhi,       // write reload high
  input  wire logic [7:0] wdata,        // write data
  output logic      [15:0] count_q,     // count value
  output logic      [15:0] rcap_q,      // reload/capture pair
  output logic            ovf_flag_q,   // overflow flag
  output logic            ext_flag_q,   // external flag
  output logic            baud_ovf      // overflow pulse
);
  logic [15:0] count_d;
  logic [15:0] rcap_d;
  logic        ovf_flag_d;
  logic        ext_flag_d;
  logic        baud_mode;
  logic        tick;
  logic        div_q;
  logic        div_d;
  logic        ext_hit;

  always_comb begin
    baud_mode  = ctrl[CB_TX_RATE] | ctrl[CB_RX_RATE];
    div_d      = baud_mode ? ~div_q : 1'b0;
    // [RQ17] pin or clock source
    tick       = ctrl[CB_RUN] & (ctrl[CB_PIN_CNT] ? count_evt : (baud_mode ? div_q : 1'b1));
    baud_ovf   = tick & baud_mode & (count_q == 16'hffff);
    ext_hit    = trig_fall & ctrl[CB_EXT_EN];
    count_d    = count_q;
    rcap_d     = rcap_q;
    ovf_flag_d = ovf_flag_q & ~ovf_clr;
    ext_flag_d = ext_flag_q & ~ext_clr;
    // [RQ1] mode select, stop
    if (tick) begin
      if (count_q == 16'hffff) begin
        // [RQ6] no overflow flag in baud
        if (baud_mode || !ctrl[CB_CAPTURE]) begin
          count_d = rcap_q;
        end else begin
          count_d = 16'h0000;
        end
        // [RQ2] [RQ4] overflow flag
        if (!baud_mode) begin
          ovf_flag_d = 1'b1;
        end
      end else begin
        count_d = count_q + 16'h0001;
      end
    end
    // [RQ6] external flag still works
    if (ext_hit) begin
      ext_flag_d = 1'b1;
      if (!baud_mode && ctrl[CB_CAPTURE]) begin
        // [RQ5] capture count
        rcap_d = count_q;
      end else if (!baud_mode) begin
        // [RQ3] trigger reload
        count_d = rcap_q;
      end
    end
    // software writes win over counting
    if (wr_lo) begin
      count_d[7:0] = wdata;
    end
    if (wr_hi) begin
      count_d[15:8] = wdata;
    end
    if (wr_rlo) begin
      rcap_d[7:0] = wdata;
    end
    if (wr_rhi) begin
      rcap_d[15:8] = wdata;
    end
  end

  // [RQ22] bytes reset to zero
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count_q    <= 16'h0000;
      rcap_q     <= 16'h0000;
      ovf_flag_q <= 1'b0;
      ext_flag_q <= 1'b0;
      div_q      <= 1'b0;
    end else begin
      count_q    <= count_d;
      rcap_q     <= rcap_d;
      ovf_flag_q <= ovf_flag_d;
      ext_flag_q <= ext_flag_d;
      div_q      <= div_d;
    end
  end
endmodule

// ===== core/sbc_pkg.sv
// constants for the serial port and counter b block
package sbc_pkg;
  // ********************************
  // register addresses
  // ********************************
  localparam logic [7:0] ADDR_SER_CTRL  = 8'h98;
  localparam logic [7:0] ADDR_SER_BUF   = 8'h99;
  localparam logic [7:0] ADDR_CB_CTRL   = 8'hc8;
  localparam logic [7:0] ADDR_RCAP_LO   = 8'hca;
  localparam logic [7:0] ADDR_RCAP_HI   = 8'hcb;
  localparam logic [7:0] ADDR_CB_LO     = 8'hcc;
  localparam logic [7:0] ADDR_CB_HI     = 8'hcd;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  // ********************************
  // serial control bit positions
  // ********************************
  localparam int SC_MODE_HI = 7;
  localparam int SC_MODE_LO = 6;
  localparam int SC_MPROC   = 5;
  localparam int SC_RX_EN   = 4;
  localparam int SC_TX9     = 3;
  localparam int SC_RX9     = 2;
  localparam int SC_TX_DONE = 1;
  localparam int SC_RX_DONE = 0;
  // ********************************
  // counter b control bit positions
  // ********************************
  localparam int CB_OVF     = 7;
  localparam int CB_EXT     = 6;
  localparam int CB_RX_RATE = 5;
  localparam int CB_TX_RATE = 4;
  localparam int CB_EXT_EN  = 3;
  localparam int CB_RUN     = 2;
  localparam int CB_PIN_CNT = 1;
  localparam int CB_CAPTURE = 0;
  // ********************************
  // timing
  // ********************************
  localparam int SHIFT_DIV    = 2;
  localparam int FIXED_DIV_LO = 32;
  localparam int FIXED_DIV_HI = 16;
  localparam int OVF_PER_BIT  = 16;
  localparam int OVS          = 16;
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_8VAR  = 2'h1;
  localparam logic [1:0] MODE_9FIX  = 2'h2;
  localparam logic [1:0] MODE_9VAR  = 2'h3;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_RUN  = 4'b0010,
    ST_STOP = 4'b0100,
    ST_END  = 4'b1000
  } sbc_state_t;
endpackage

// ===== core/sbc_top.sv
// serial port with counter b baud source
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] counter b mode from control bits
// [RQ2] rollover sets overflow and reloads
// [RQ3] trigger falling edge reloads, sets external
// [RQ4] capture mode counts and flags overflow
// [RQ5] trigger edge captures count into pair
// [RQ6] no overflow flag in baud mode
// [RQ7] full duplex, receive buffered, overrun loses
// [RQ8] buffer write transmits, read receive register
// [RQ9] mode bits pick frame and rate
// [RQ10] 8-bit multiproc needs valid stop
// [RQ11] 9-bit multiproc needs ninth bit one
// [RQ12] receive only while enable set
// [RQ13] send tx ninth bit in 9-bit
// [RQ14] latch ninth or stop bit
// [RQ15] tx done timing, software clears
// [RQ16] rx done timing, software clears
// [RQ17] pin select counts pin edges
// [RQ18] 8-bit frame is ten bits
// [RQ19] 9-bit frame is eleven bits
// [RQ20] sixteen overflows per bit
// [RQ21] one serial interrupt request
// [RQ22] counter bytes readable, reset zero
module sbc_top
  import sbc_pkg::*;
(
  input  wire logic       core_clk,       // core clock
  input  wire logic       resetn,         // sync reset, low
  input  wire logic [7:0] reg_addr,       // register address
  input  wire logic       reg_wr,         // write strobe
  input  wire logic       reg_rd,         // read strobe
  input  wire logic [7:0] reg_wdata,      // write data
  output logic      [7:0] reg_rdata,      // read data
  input  wire logic       fixed_fast,     // fixed rate x2 select
  input  wire logic       rx_pin,         // serial receive pin
  output logic            rx_pin_out,     // shift mode data out
  output logic            rx_pin_oe,      // shift mode drive enable
  output logic            tx_pin,         // serial transmit pin
  input  wire logic       counter_b_count_pin,   // counter b count pin
  input  wire logic       counter_b_trigger_pin, // counter b trigger pin
  output logic            serial_irq,     // serial interrupt
  output logic            counter_b_irq   // counter b interrupt
);
  // ********************************
  // registers and pin sync
  // ********************************
  logic [7:0]  ctrl_q, ctrl_d, cbc_q, cbc_d, rbuf_q, rbuf_d;
  logic [2:0]  rxs_q, cps_q, tps_q;
  logic [15:0] cnt, rcap;
  logic        ovf_f, ext_f, bovf;
  logic        wr_sc, wr_buf, wr_cbc;
  logic [1:0]  mode;
  logic        rx_s, cnt_evt, trig_fall;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rxs_q <= 3'h7;
      cps_q <= 3'h0;
      tps_q <= 3'h7;
    end else begin
      rxs_q <= {rxs_q[1:0], rx_pin};
      cps_q <= {cps_q[1:0], counter_b_count_pin};
      tps_q <= {tps_q[1:0], counter_b_trigger_pin};
    end
  end

  assign rx_s      = rxs_q[1];
  assign cnt_evt   = cps_q[2] & ~cps_q[1];
  assign trig_fall = tps_q[2] & ~tps_q[1];
  assign mode      = {ctrl_q[SC_MODE_HI], ctrl_q[SC_MODE_LO]};
  assign wr_sc     = reg_wr && (reg_addr == ADDR_SER_CTRL);
  assign wr_buf    = reg_wr && (reg_addr == ADDR_SER_BUF);
  assign wr_cbc    = reg_wr && (reg_addr == ADDR_CB_CTRL);

  sbc_counter_b u_cb (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .ctrl      (cbc_q),
    .ovf_clr   (wr_cbc & ~reg_wdata[CB_OVF]),
    .ext_clr   (wr_cbc & ~reg_wdata[CB_EXT]),
    .count_evt (cnt_evt),
    .trig_fall (trig_fall),
    .wr_lo     (reg_wr && (reg_addr == ADDR_CB_LO)),
    .wr_hi     (reg_wr && (reg_addr == ADDR_CB_HI)),
    .wr_rlo    (reg_wr && (reg_addr == ADDR_RCAP_LO)),
    .wr_rhi    (reg_wr && (reg_addr == ADDR_RCAP_HI)),
    .wdata     (reg_wdata),
    .count_q   (cnt),
    .rcap_q    (rcap),
    .ovf_flag_q(ovf_f),
    .ext_flag_q(ext_f),
    .baud_ovf  (bovf)
  );

  // ********************************
  // bit rate enables
  // ********************************
  logic [4:0] fdiv_q, fdiv_d;
  logic [3:0] tbd_q, tbd_d;
  logic       fix_tick, shift_tick, tx_os, rx_os, var_src_tx, var_src_rx;

  always_comb begin
    fdiv_d     = fdiv_q + 5'h01;
    // [RQ9] fixed rates from core clock
    shift_tick = fdiv_q[0];
    fix_tick   = fixed_fast | fdiv_q[0];
    // [RQ20] counter b overflows as oversample
    var_src_tx = cbc_q[CB_TX_RATE] & bovf;
    var_src_rx = cbc_q[CB_RX_RATE] & bovf;
    tx_os      = mode == MODE_9FIX ? fix_tick : var_src_tx;
    rx_os      = mode == MODE_9FIX ? fix_tick : var_src_rx;
    tbd_d      = tbd_q + {3'h0, tx_os};
  end

  // ********************************
  // transmitter
  // ********************************
  sbc_state_t tst_q, tst_d;
  logic [10:0] tsh_q, tsh_d;
  logic [3:0]  tcnt_q, tcnt_d;
  logic        tbit;
  logic        tx_d, tx_done_set, tx_q, oe_d, oe_q, sclk_d, sclk_q;

  always_comb begin
    tst_d = tst_q;
    tsh_d = tsh_q;
    tcnt_d = tcnt_q;
    tx_done_set = 1'b0;
    tx_d = tx_q;
    oe_d = oe_q;
    sclk_d = sclk_q;
    tbit = (mode == MODE_SHIFT) ? shift_tick : (tx_os && tbd_q == 4'hf);
    case (tst_q)
      ST_IDLE: begin
        tx_d = (mode == MODE_SHIFT) ? 1'b1 : 1'b1;
        oe_d = 1'b0;
        // [RQ8] write starts transmit
        if (wr_buf) begin
          // [RQ13] [RQ18] [RQ19] frame layout
          tsh_d  = (mode[1]) ? {1'b1, ctrl_q[SC_TX9], reg_wdata, 1'b0} : {2'b11, reg_wdata, 1'b0};
          tcnt_d = (mode == MODE_SHIFT) ? 4'h8 : (mode[1] ? 4'ha : 4'h9);
          if (mode == MODE_SHIFT) begin
            tsh_d = {3'h7, reg_wdata};
          end
          tst_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (tbit) begin
          if (mode == MODE_SHIFT) begin
            oe_d   = 1'b1;
            sclk_d = ~sclk_q;
            // data changes on the falling shift clock
            if (sclk_q) begin
              tx_d = tsh_q[0];
            end else begin
              tsh_d  = {1'b1, tsh_q[10:1]};
              tcnt_d = tcnt_q - 4'h1;
              // [RQ15] end of eighth bit
              if (tcnt_q == 4'h1) begin
                tx_done_set = 1'b1;
                tst_d = ST_IDLE;
              end
            end
          end else begin
            tx_d   = tsh_q[0];
            tsh_d  = {1'b1, tsh_q[10:1]};
            tcnt_d = tcnt_q - 4'h1;
            if (tcnt_q == 4'h0) begin
              // [RQ15] stop bit begins
              tx_done_set = 1'b1;
              tst_d = ST_STOP;
            end
          end
        end
      end
      ST_STOP: begin
        if (tbit) begin
          tst_d = ST_IDLE;
        end
      end
      default: tst_d = ST_IDLE;
    endcase
  end

  // ********************************
  // receiver
  // ********************************
  sbc_state_t rst_q, rst_d;
  logic [8:0] rsh_q, rsh_d;
  logic [3:0] rcnt_q, rcnt_d, rph_q, rph_d;
  logic       rx_done_set, rx9_set, rx9_val, rsamp;

  always_comb begin
    rst_d = rst_q;
    rsh_d = rsh_q;
    rcnt_d = rcnt_q;
    rph_d = rph_q;
    rbuf_d = rbuf_q;
    rx_done_set = 1'b0;
    rx9_set = 1'b0;
    rx9_val = 1'b0;
    rsamp = rx_os && rph_q == 4'h7;
    case (rst_q)
      ST_IDLE: begin
        // [RQ12] receive enable gate
        if (ctrl_q[SC_RX_EN] && mode != MODE_SHIFT && !rx_s) begin
          rph_d = 4'h0;
          rcnt_d = mode[1] ? 4'ha : 4'h9;
          rst_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (rx_os) begin
          rph_d = rph_q + 4'h1;
        end
        if (rsamp) begin
          if (rcnt_q == (mode[1] ? 4'ha : 4'h9) && rx_s) begin
            rst_d = ST_IDLE;
          end else if (rcnt_q == 4'h0) begin
            // [RQ16] halfway through stop bit
            rst_d = ST_END;
            // [RQ10] [RQ11] multiproc gates flag
            if (!(ctrl_q[SC_MPROC] && (mode[1] ? !rsh_q[8] : !rx_s))) begin
              // [RQ7] unread byte overwritten
              rbuf_d = mode[1] ? rsh_q[7:0] : rsh_q[8:1];
              rx_done_set = 1'b1;
              rx9_set = 1'b1;
              // [RQ14] ninth or stop bit
              rx9_val = mode[1] ? rsh_q[8] : rx_s;
            end
          end else begin
            rsh_d = {rx_s, rsh_q[8:1]};
            rcnt_d = rcnt_q - 4'h1;
          end
        end
      end
      default: begin
        if (rx_s) begin
          rst_d = ST_IDLE;
        end
      end
    endcase
  end

  // ********************************
  // control registers
  // ********************************
  always_comb begin
    ctrl_d = wr_sc ? reg_wdata : ctrl_q;
    cbc_d  = wr_cbc ? reg_wdata : cbc_q;
    // [RQ15] [RQ16] set wins over clear
    if (tx_done_set) begin
      ctrl_d[SC_TX_DONE] = 1'b1;
    end
    if (rx_done_set) begin
      ctrl_d[SC_RX_DONE] = 1'b1;
    end
    if (rx9_set) begin
      ctrl_d[SC_RX9] = rx9_val;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_q <= RESET_BYTE;
      cbc_q  <= RESET_BYTE;
      rbuf_q <= RESET_BYTE;
      fdiv_q <= 5'h00;
      tbd_q  <= 4'h0;
      tst_q  <= ST_IDLE;
      tsh_q  <= 11'h7ff;
      tcnt_q <= 4'h0;
      tx_q   <= 1'b1;
      oe_q   <= 1'b0;
      sclk_q <= 1'b1;
      rst_q  <= ST_IDLE;
      rsh_q  <= 9'h000;
      rcnt_q <= 4'h0;
      rph_q  <= 4'h0;
    end else begin
      ctrl_q <= ctrl_d;
      cbc_q  <= cbc_d;
      rbuf_q <= rbuf_d;
      fdiv_q <= fdiv_d;
      tbd_q  <= tbd_d;
      tst_q  <= tst_d;
      tsh_q  <= tsh_d;
      tcnt_q <= tcnt_d;
      tx_q   <= tx_d;
      oe_q   <= oe_d;
      sclk_q <= sclk_d;
      rst_q  <= rst_d;
      rsh_q  <= rsh_d;
      rcnt_q <= rcnt_d;
      rph_q  <= rph_d;
    end
  end

  // ********************************
  // outputs and read mux
  // ********************************
  always_comb begin
    if (reg_addr == ADDR_SER_CTRL) begin
      reg_rdata = ctrl_q;
    end else if (reg_addr == ADDR_SER_BUF) begin
      // [RQ8] separate receive register
      reg_rdata = rbuf_q;
    end else if (reg_addr == ADDR_CB_CTRL) begin
      reg_rdata = {ovf_f, ext_f, cbc_q[5:0]};
    end else if (reg_addr == ADDR_RCAP_LO) begin
      reg_rdata = rcap[7:0];
    end else if (reg_addr == ADDR_RCAP_HI) begin
      reg_rdata = rcap[15:8];
    end else if (reg_addr == ADDR_CB_LO) begin
      // [RQ22] counter bytes readable
      reg_rdata = cnt[7:0];
    end else if (reg_addr == ADDR_CB_HI) begin
      reg_rdata = cnt[15:8];
    end else begin
      reg_rdata = 8'h00;
    end
  end

  assign tx_pin     = (mode == MODE_SHIFT) ? sclk_q : tx_q;
  assign rx_pin_out = tx_q;
  assign rx_pin_oe  = oe_q & (mode == MODE_SHIFT);
  // [RQ21] combined serial request
  assign serial_irq    = ctrl_q[SC_TX_DONE] | ctrl_q[SC_RX_DONE];
  assign counter_b_irq = ovf_f | ext_f;
endmodule

// ===== verification/sbc_remote.sv
// remote serial device model
`timescale 1ns/1ps
module sbc_remote (
  input  wire logic        core_clk, // core clock
  input  wire logic        tx_pin,   // device transmit pin
  input  wire logic [15:0] bit_cyc,  // clocks per bit
  input  wire logic [3:0]  nbits,    // bits per frame
  output logic             rx_pin,   // device receive pin
  output logic      [10:0] got,      // last frame seen
  output logic             got_vld   // frame seen
);
  initial begin
    rx_pin = 1'b1;
    got_vld = 1'b0;
  end
  task automatic send(input logic [10:0] f);
    for (int i = 0; i <= nbits; i++) begin
      @(negedge core_clk);
      rx_pin = (i < nbits) ? f[i] : 1'b1;
      repeat (bit_cyc - 1) @(negedge core_clk);
    end
  endtask
  // frame sampled mid-bit
  always begin
    @(negedge tx_pin);
    got = 11'h000;
    repeat (bit_cyc / 2) @(negedge core_clk);
    for (int i = 0; i < nbits; i++) begin
      got[i] = tx_pin;
      repeat (bit_cyc) @(negedge core_clk);
    end
    got_vld = 1'b1;
    @(negedge core_clk);
    got_vld = 1'b0;
  end
endmodule

// ===== verification/sbc_top_asserts.sv
// assertion checker for the serial port and counter b block
`timescale 1ns/1ps
module sbc_top_asserts
  import sbc_pkg::*;
(
  input wire logic       core_clk,     // core clock
  input wire logic       resetn,       // sync reset, low
  input wire logic [7:0] reg_addr,     // register address
  input wire logic       reg_wr,       // write strobe
  input wire logic [7:0] reg_wdata,    // write data
  input wire logic [7:0] reg_rdata,    // read data
  input wire logic       tx_pin,       // transmit pin
  input wire logic       rx_pin_oe,    // shift drive enable
  input wire logic       serial_irq,   // serial interrupt
  input wire logic       counter_b_irq // counter b interrupt
);
  // ********************************
  // frame mode shadow
  // ********************************
  logic [1:0] mode_d;
  logic [1:0] mode_q;
  always_comb begin
    mode_d = mode_q;
    if (reg_wr && reg_addr == ADDR_SER_CTRL) mode_d = reg_wdata[7:6];
  end
  always_ff @(posedge core_clk) begin
    if (!resetn) mode_q <= MODE_SHIFT;
    else mode_q <= mode_d;
  end
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_buf_wr;
    reg_wr && reg_addr == ADDR_SER_BUF && mode_q != MODE_SHIFT && tx_pin;
  endsequence
  sequence s_rcap_wr;
    reg_wr && reg_addr == ADDR_RCAP_HI ##1 reg_addr == ADDR_RCAP_HI;
  endsequence
  a_reset_idle: assert property ($rose(resetn) |-> tx_pin && !rx_pin_oe && !serial_irq && !counter_b_irq)
    else $error("outputs not idle after reset");
  a_tx_start: assert property (s_buf_wr |-> ##[1:200] !tx_pin)
    else $error("no start bit after buffer write");
  a_ser_irq: assert property (reg_addr == ADDR_SER_CTRL |->
    serial_irq == (reg_rdata[SC_TX_DONE] | reg_rdata[SC_RX_DONE]))
    else $error("serial irq not done flags");
  a_cb_irq_map: assert property (reg_addr == ADDR_CB_CTRL |->
    counter_b_irq == (reg_rdata[CB_OVF] | reg_rdata[CB_EXT]))
    else $error("counter irq not flags");
  a_baud_no_ovf: assert property (reg_addr == ADDR_CB_CTRL && (reg_rdata[CB_RX_RATE] | reg_rdata[CB_TX_RATE])
    |-> !reg_rdata[CB_OVF])
    else $error("overflow flag in baud mode");
  a_ser_sticky: assert property (serial_irq && !(reg_wr && reg_addr == ADDR_SER_CTRL) |=> serial_irq)
    else $error("serial flag dropped alone");
  a_oe_shift: assert property (rx_pin_oe |-> mode_q == MODE_SHIFT)
    else $error("data drive outside shift mode");
  a_rcap_rw: assert property (s_rcap_wr |-> reg_rdata == $past(reg_wdata))
    else $error("reload byte not written");
endmodule
bind sbc_top sbc_top_asserts u_sbc_top_asserts (
  .core_clk(core_clk),
  .resetn(resetn),
  .reg_addr(reg_addr),
  .reg_wr(reg_wr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .tx_pin(tx_pin),
  .rx_pin_oe(rx_pin_oe),
  .serial_irq(serial_irq),
  .counter_b_irq(counter_b_irq)
);

// ===== verification/sbc_top_tb.sv
// self-checking bench for the serial port and counter b block
`timescale 1ns/1ps
module sbc_top_tb;
  import sbc_pkg::*;
  logic        core_clk, resetn, reg_wr, reg_rd, fixed_fast, rem_rx, rx_line, cnt_pin, trg_pin;
  logic        rx_pin_out, rx_pin_oe, tx_pin, serial_irq, counter_b_irq, got_vld, tb8, n9;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, r, d2, d3, sh;
  logic [1:0]  md;
  logic [15:0] bit_cyc;
  logic [3:0]  nbits;
  logic [10:0] got;
  logic [7:0]  exp_rd[$];
  logic [10:0] exp_fr[$];
  logic [7:0]  addrs[8] = '{ADDR_SER_CTRL, ADDR_SER_BUF, ADDR_CB_CTRL, ADDR_RCAP_LO, ADDR_RCAP_HI,
                            ADDR_CB_LO, ADDR_CB_HI, 8'h50};
  int          failures, checks_done, cyc;
  assign rx_line = rx_pin_oe ? rx_pin_out : rem_rx;
  sbc_top u_sbc_top (.core_clk(core_clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .fixed_fast(fixed_fast),
    .rx_pin(rx_line), .rx_pin_out(rx_pin_out), .rx_pin_oe(rx_pin_oe), .tx_pin(tx_pin),
    .counter_b_count_pin(cnt_pin), .counter_b_trigger_pin(trg_pin), .serial_irq(serial_irq),
    .counter_b_irq(counter_b_irq));
  sbc_remote u_sbc_remote (.core_clk(core_clk), .tx_pin(tx_pin), .bit_cyc(bit_cyc), .nbits(nbits),
    .rx_pin(rem_rx), .got(got), .got_vld(got_vld));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // ********************************
  // tasks
  // ********************************
  task automatic chk(input string n, input logic [10:0] e, input logic [10:0] s);
    checks_done++;
    if (e !== s) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge core_clk);
    reg_wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    reg_addr = a;
    reg_rd = 1'b1;
    exp_rd.push_back(e);
    @(negedge core_clk);
    reg_rd = 1'b0;
  endtask
  task automatic wait_for(input int sel, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge core_clk);
      if (sel == 0 && counter_b_irq === 1'b1) return;
      if (sel == 1 && serial_irq === 1'b1) return;
      if (sel == 2 && exp_fr.size() == 0) return;
    end
    chk("wait", 11'h001, 11'h000);
  endtask
  task automatic pulse_trg();
    @(negedge core_clk);
    trg_pin = 1'b0;
    wait_for(0, 40);
    trg_pin = 1'b1;
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ********************************
  // monitor and timeout
  // ********************************
  always @(posedge core_clk) begin
    #1;
    if (reg_rd === 1'b1 && exp_rd.size() > 0) chk("reg_rdata", {3'h0, exp_rd.pop_front()}, {3'h0, reg_rdata});
    if (got_vld === 1'b1 && exp_fr.size() > 0) chk("frame", exp_fr.pop_front(), got);
  end
  // shift mode data, taken on the rising shift clock
  always @(posedge tx_pin) begin
    if (rx_pin_oe === 1'b1) sh = {rx_pin_out, sh[7:1]};
  end
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 40000) begin
      failures++;
      end_sim();
    end
  end
  // ********************************
  // main sequence
  // ********************************
  initial begin
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    fixed_fast = 1'b0;
    cnt_pin = 1'b1;
    trg_pin = 1'b1;
    bit_cyc = 16'h0040;
    nbits = 4'ha;
    failures = 0;
    checks_done = 0;
    cyc = 0;
    void'($urandom(47226));
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    foreach (addrs[i]) rd(addrs[i], 8'h00);
    for (int i = 0; i < 4; i++) begin
      r = 8'($urandom);
      wr(ADDR_RCAP_LO + 8'(i), r);
      rd(ADDR_RCAP_LO + 8'(i), r);
    end
    r = 8'($urandom_range(112, 16));
    wr(ADDR_RCAP_HI, r);
    wr(ADDR_RCAP_LO, 8'h00);
    wr(ADDR_CB_HI, 8'hff);
    wr(ADDR_CB_LO, 8'hf0);
    wr(ADDR_CB_CTRL, 8'h04);
    wait_for(0, 2000);
    rd(ADDR_CB_HI, r);
    rd(ADDR_CB_CTRL, 8'h84);
    wr(ADDR_CB_CTRL, 8'h0c);
    wr(ADDR_CB_HI, 8'h00);
    pulse_trg();
    rd(ADDR_CB_HI, r);
    rd(ADDR_CB_CTRL, 8'h4c);
    wr(ADDR_CB_HI, 8'hff);
    wr(ADDR_CB_LO, 8'h80);
    wr(ADDR_CB_CTRL, 8'h0d);
    pulse_trg();
    rd(ADDR_RCAP_HI, 8'hff);
    wr(ADDR_CB_CTRL, 8'h0d);
    wait_for(0, 2000);
    rd(ADDR_CB_CTRL, 8'h8d);
    rd(ADDR_CB_HI, 8'h00);
    wr(ADDR_CB_CTRL, 8'h00);
    wr(ADDR_CB_LO, 8'h00);
    wr(ADDR_CB_CTRL, 8'h06);
    repeat (5) begin
      @(negedge core_clk);
      cnt_pin = 1'b0;
      repeat (4) @(negedge core_clk);
      cnt_pin = 1'b1;
      repeat (4) @(negedge core_clk);
    end
    rd(ADDR_CB_LO, 8'h05);
    wr(ADDR_CB_CTRL, 8'h00);
    for (int i = 0; i < 4; i++) wr(ADDR_RCAP_LO + 8'(i), i[0] ? 8'hff : 8'hfe);
    wr(ADDR_CB_CTRL, 8'h34);
    for (int m = 1; m < 5; m++) begin
      md = (m == 4) ? MODE_9FIX : 2'(m);
      fixed_fast = (m == 4);
      bit_cyc = (m == 4) ? 16'h0010 : ((m == 2) ? 16'h0020 : 16'h0040);
      nbits = (m == 1) ? 4'ha : 4'hb;
      {r, d2, d3} = 24'($urandom);
      tb8 = 1'($urandom);
      n9 = 1'($urandom);
      wr(ADDR_SER_CTRL, {md, 2'b01, tb8, 3'h0});
      exp_fr.push_back((m == 1) ? {2'b01, r, 1'b0} : {1'b1, tb8, r, 1'b0});
      fork
        wr(ADDR_SER_BUF, r);
        u_sbc_remote.send({1'b1, n9 | (m == 1), d2, 1'b0});
      join
      wait_for(2, 2000);
      rd(ADDR_SER_CTRL, {md, 2'b01, tb8, n9 | (m == 1), 2'b11});
      rd(ADDR_SER_BUF, d2);
      u_sbc_remote.send({2'b11, d3, 1'b0});
      rd(ADDR_SER_BUF, d3);
      wr(ADDR_SER_CTRL, {md, 2'b11, tb8, 3'h0});
      u_sbc_remote.send({2'b10, d2, 1'b0});
      rd(ADDR_SER_BUF, d3);
      rd(ADDR_SER_CTRL, {md, 2'b11, tb8, 3'h0});
      wr(ADDR_SER_CTRL, {md, 2'b00, tb8, 3'h0});
      u_sbc_remote.send({2'b11, d2, 1'b0});
      rd(ADDR_SER_BUF, d3);
      rd(ADDR_SER_CTRL, {md, 2'b00, tb8, 3'h0});
    end
    wr(ADDR_SER_CTRL, 8'h00);
    wr(ADDR_SER_BUF, r);
    wait_for(1, 200);
    rd(ADDR_SER_CTRL, 8'h02);
    chk("shift_data", {3'h0, r}, {3'h0, sh});
    end_sim();
  end
endmodule
